// >>> rosr_params.svh
// Constants for the reclocker override and status register slice.
// Assumes a 100 MHz core clock and 16-bit registers behind the host port.
`ifndef ROSR_PARAMS_SVH
`define ROSR_PARAMS_SVH

`define ROSR_ADDR_TOP_CTRL      8'h02
`define ROSR_ADDR_PIN_OVERRIDE  8'h0c
`define ROSR_ADDR_STATUS        8'h0d

`define ROSR_POWER_DOWN_BIT     3
`define ROSR_OVR_ENABLE_BIT     0
`define ROSR_OVR_INSEL_LO_BIT   1
`define ROSR_OVR_INSEL_HI_BIT   2
`define ROSR_OVR_BYPASS_BIT     3
`define ROSR_OVR_AUTOBYP_BIT    4
`define ROSR_OVR_AUTO_BIT       5
`define ROSR_OVR_RATE_LO_BIT    6
`define ROSR_OVR_RATE_HI_BIT    7
`define ROSR_OVR_TLC_LSB        8
`define ROSR_OVR_MUTE_BIT       10
`define ROSR_OVR_OUT2_OFF_BIT   11
`define ROSR_OVR_DATACLK_BIT    12

`define ROSR_PIN_OVERRIDE_RST   16'h0000
`define ROSR_TOP_CTRL_RST       16'h0000

`define ROSR_TLC_GROUND         2'h0
`define ROSR_TLC_INVALID        2'h1
`define ROSR_TLC_FLOAT          2'h2
`define ROSR_TLC_SUPPLY         2'h3

`define ROSR_LOCK_TIME_NS       10000
`define ROSR_CLK_PERIOD_NS      10
`define ROSR_LOCK_CYCLES        (`ROSR_LOCK_TIME_NS / `ROSR_CLK_PERIOD_NS)

`endif

// >>> rosr_pkg.sv
// Types shared by the reclocker override and status register slice.
// Assumes the constants header is included by the design files.
package rosr_pkg;

  // Three-level configuration pin state
  typedef enum logic [1:0] {
    ROSR_LVL_GROUND,
    ROSR_LVL_FLOAT,
    ROSR_LVL_SUPPLY
  } rosr_level_t;

  // Configuration as seen by the datapath, whether from pins or register
  typedef struct packed {
    logic        data_not_clock;
    logic        second_output_off;
    logic        data_mute;
    rosr_level_t three_level_config_field;
    logic        rate_select_high;
    logic        rate_select_low;
    logic        automatic_rate_mode;
    logic        autobypass;
    logic        bypass;
    logic        input_select_high;
    logic        input_select_low;
  } rosr_cfg_t;

  // Live indications from the recovery core
  typedef struct packed {
    logic low_rate_indicator;
    logic locked;
    logic rate_select_high;
    logic rate_select_low_status;
  } rosr_status_t;

endpackage

// >>> rosr_lock_timer.sv
// Start-up lock qualifier: counts from any state, needs no reset to recover.
// Assumes a single synchronous clock and a clock enable that freezes it.
`include "rosr_params.svh"

module rosr_lock_timer #(
  parameter int LOCK_CYCLES = `ROSR_LOCK_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_ce,
  input  wire logic i_restart,
  input  wire logic i_core_lock,
  output logic      o_locked
);

  logic [15:0] count_reg;

  // Counter saturates; any garbage start value simply runs out or restarts
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (i_restart || !i_core_lock) begin
        count_reg <= 16'h0000;
      end else if (count_reg < 16'(LOCK_CYCLES)) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // Lock claimed only after the qualification time; self-corrects each cycle
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_locked <= !i_restart && i_core_lock && (count_reg >= 16'(LOCK_CYCLES));
    end
  end

endmodule // rosr_lock_timer

// >>> rosr_regs.sv
// Override and status register slice of a multi-rate serial reclocker.
// Assumes a host port decoder delivering register read/write strobes.
`include "rosr_params.svh"

module rosr_regs #(
  parameter int LOCK_CYCLES = `ROSR_LOCK_CYCLES
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  input  wire logic                  i_host_mode_pin,
  input  wire logic                  i_cmd_reg_reset_n,
  input  wire logic                  i_wr_en,
  input  wire logic                  i_rd_en,
  input  wire logic [7:0]            i_addr,
  input  wire logic [15:0]           i_wdata,
  input  wire rosr_pkg::rosr_cfg_t   i_pin_cfg,
  input  wire rosr_pkg::rosr_status_t i_core_status,
  output logic [15:0]                o_rdata,
  output logic                       o_rvalid,
  output rosr_pkg::rosr_cfg_t        o_cfg,
  output logic                       o_tlc_invalid,
  output logic                       o_power_down,
  output logic                       o_locked
);

  logic [15:0]            pin_override_control_reg;
  logic [15:0]            top_control_reg;
  logic                   mode_pin_q_reg;
  logic                   por_done_reg;
  logic                   reg_clear;
  logic                   locked_w;
  rosr_pkg::rosr_cfg_t    cfg_next;
  logic [15:0]            status_w;
  logic                   ovr_active;
  logic                   standby;

  // Map the two-bit register encoding onto a pin level
  function automatic rosr_pkg::rosr_level_t tlc_decode(input logic [1:0] code);
    case (code)
      `ROSR_TLC_GROUND: tlc_decode = rosr_pkg::ROSR_LVL_GROUND;
      `ROSR_TLC_FLOAT:  tlc_decode = rosr_pkg::ROSR_LVL_FLOAT;
      `ROSR_TLC_SUPPLY: tlc_decode = rosr_pkg::ROSR_LVL_SUPPLY;
      default:          tlc_decode = rosr_pkg::ROSR_LVL_FLOAT;  // Invalid code treated as floating
    endcase
  endfunction

  // Three-level code of an override word; read by the mux and the invalid flag
  function automatic logic [1:0] tlc_field(input logic [15:0] word);
    tlc_field = word[`ROSR_OVR_TLC_LSB+1:`ROSR_OVR_TLC_LSB];
  endfunction

  // Write strobe aimed at one register address
  function automatic logic write_hit(input logic       en,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
    write_hit = en && (addr == target);
  endfunction

  // Status word; reserved upper bits are tied to zero so they never float
  function automatic logic [15:0] status_word(input rosr_pkg::rosr_status_t st,
                                              input logic                   lock);
    status_word = {12'h000, st.low_rate_indicator, lock,
                   st.rate_select_high, st.rate_select_low_status};
  endfunction

  // Mode pin copy; feeds the host-command clear, while the power-up clear reads the strap directly
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_pin_q_reg <= 1'b0;
    end else if (i_ce) begin
      mode_pin_q_reg <= i_host_mode_pin;
    end
  end

  // First enabled edge after reset closes the power-up window
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      por_done_reg <= 1'b0;
    end else if (i_ce) begin
      por_done_reg <= 1'b1;
    end
  end

  // Power-up clear in non-host mode, or host command with reset bit low
  assign reg_clear = (!por_done_reg && i_host_mode_pin)
                   || (por_done_reg && !mode_pin_q_reg && !i_cmd_reg_reset_n);

  // Pin override register; host writes win unless a clear is pending
  // A write that lands in a clear cycle is lost; the host must not overlap them
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_override_control_reg <= `ROSR_PIN_OVERRIDE_RST;
    end else if (i_ce) begin
      if (reg_clear) begin
        pin_override_control_reg <= `ROSR_PIN_OVERRIDE_RST;
      end else if (write_hit(i_wr_en, i_addr, `ROSR_ADDR_PIN_OVERRIDE)) begin
        pin_override_control_reg <= i_wdata;
      end
    end
  end

  // Top control register holds the power-down bit among others
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      top_control_reg <= `ROSR_TOP_CTRL_RST;
    end else if (i_ce) begin
      if (reg_clear) begin
        top_control_reg <= `ROSR_TOP_CTRL_RST;
      end else if (write_hit(i_wr_en, i_addr, `ROSR_ADDR_TOP_CTRL)) begin
        top_control_reg <= i_wdata;
      end
    end
  end

  // Shorthands read by more than one process below
  assign ovr_active = pin_override_control_reg[`ROSR_OVR_ENABLE_BIT];
  assign standby    = top_control_reg[`ROSR_POWER_DOWN_BIT];

  // Choose between package pins and register fields
  always_comb begin
    if (ovr_active) begin
      cfg_next.data_not_clock           = pin_override_control_reg[`ROSR_OVR_DATACLK_BIT];
      cfg_next.second_output_off        = pin_override_control_reg[`ROSR_OVR_OUT2_OFF_BIT];
      cfg_next.data_mute                = pin_override_control_reg[`ROSR_OVR_MUTE_BIT];
      cfg_next.three_level_config_field =
        tlc_decode(tlc_field(pin_override_control_reg));
      cfg_next.rate_select_high         = pin_override_control_reg[`ROSR_OVR_RATE_HI_BIT];
      cfg_next.rate_select_low          = pin_override_control_reg[`ROSR_OVR_RATE_LO_BIT];
      cfg_next.automatic_rate_mode      = pin_override_control_reg[`ROSR_OVR_AUTO_BIT];
      cfg_next.autobypass               = pin_override_control_reg[`ROSR_OVR_AUTOBYP_BIT];
      cfg_next.bypass                   = pin_override_control_reg[`ROSR_OVR_BYPASS_BIT];
      cfg_next.input_select_high        = pin_override_control_reg[`ROSR_OVR_INSEL_HI_BIT];
      cfg_next.input_select_low         = pin_override_control_reg[`ROSR_OVR_INSEL_LO_BIT];
    end else begin
      cfg_next = i_pin_cfg;
    end
  end

  // Configuration towards the datapath, one cycle behind its source
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cfg <= '0;
    end else if (i_ce) begin
      o_cfg <= cfg_next;
    end
  end

  // Code one is flagged only while the register, not the pins, is in charge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tlc_invalid <= 1'b0;
    end else if (i_ce) begin
      o_tlc_invalid <= ovr_active &&
                       (tlc_field(pin_override_control_reg) == `ROSR_TLC_INVALID);
    end
  end

  // Standby request towards the rest of the device
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_power_down <= 1'b0;
    end else if (i_ce) begin
      o_power_down <= standby;
    end
  end

  // Lock qualifier restarts while powered down
  // It has no reset of its own, so it must recover from any start value
  rosr_lock_timer #(
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_lock_timer (
    .i_clk       (i_clk),
    .i_ce        (i_ce),
    .i_restart   (standby),
    .i_core_lock (i_core_status.locked),
    .o_locked    (locked_w)
  );

  // Qualified lock registered once more so the output comes from a flop
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_locked <= 1'b0;
    end else if (i_ce) begin
      o_locked <= locked_w;
    end
  end

  // Live status word
  assign status_w = status_word(i_core_status, locked_w);

  // Read answer strobe, one cycle after the request
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_rvalid <= i_rd_en;
    end
  end

  // Read data: unmapped addresses read zero
  // Held between reads so a slow host may pick it up late
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (i_ce && i_rd_en) begin
      case (i_addr)
        `ROSR_ADDR_TOP_CTRL:     o_rdata <= top_control_reg;
        `ROSR_ADDR_PIN_OVERRIDE: o_rdata <= pin_override_control_reg;
        `ROSR_ADDR_STATUS:       o_rdata <= status_w;
        default:                 o_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // rosr_regs

// >>> rosr_regs_properties.sv
// Timing checks on the register slice ports.
// Assumes one clock; strobes are sampled on the rising edge.
module rosr_regs_chk (
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  input wire logic                   i_ce,
  input wire logic                   i_host_mode_pin,
  input wire logic                   i_cmd_reg_reset_n,
  input wire logic                   i_wr_en,
  input wire logic                   i_rd_en,
  input wire logic [7:0]             i_addr,
  input wire logic [15:0]            i_wdata,
  input wire rosr_pkg::rosr_status_t i_core_status,
  input wire logic [15:0]            o_rdata,
  input wire logic                   o_rvalid,
  input wire rosr_pkg::rosr_cfg_t    o_cfg,
  input wire logic                   o_tlc_invalid,
  input wire logic                   o_power_down,
  input wire logic                   o_locked
);
  logic clr_n;
  // A host-mode clear beats writes, so write checks need it inactive
  assign clr_n = i_host_mode_pin | i_cmd_reg_reset_n;
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_read_answer: assert property (i_ce && i_rd_en |=> o_rvalid) else $error("no rvalid");
  a_status_read: assert property (
    i_ce && i_rd_en && i_addr == 8'h0d |=> o_rdata[15:4] == 12'h000 && o_rdata[3] == $past(i_core_status[3])
    && o_rdata[1:0] == $past(i_core_status[1:0])) else $error("status read");
  a_override_map: assert property (
    i_ce && i_wr_en && i_addr == 8'h0c && i_wdata[0] && clr_n ##1 i_ce && !i_wr_en && clr_n |=> o_cfg.data_mute
    == $past(i_wdata[10], 2) && o_tlc_invalid == ($past(i_wdata[9:8], 2) == 2'h1)) else $error("override");
  a_tlc_float: assert property (
    o_tlc_invalid |-> o_cfg.three_level_config_field == rosr_pkg::ROSR_LVL_FLOAT) else $error("code one");
  a_power_bit: assert property (
    i_ce && i_wr_en && i_addr == 8'h02 && clr_n ##1 i_ce && !i_wr_en && clr_n
    |=> o_power_down == $past(i_wdata[3], 2)) else $error("power down");
  a_host_clear: assert property (
    (!i_host_mode_pin && !i_cmd_reg_reset_n && i_ce) [*2] |=> !o_power_down) else $error("host clear");
  a_reset_quiet: assert property (
    disable iff (1'b0) i_rst && i_ce |=> !o_power_down && !o_locked && !o_rvalid) else $error("reset");
  a_lock_drop: assert property (!i_core_status.locked && i_ce ##1 i_ce |=> !o_locked) else $error("lock");
  c_status: cover property (i_rd_en && i_addr == 8'h0d);
  c_locked: cover property ($rose(o_locked));
  c_invalid: cover property (o_tlc_invalid);
endmodule // rosr_regs_chk

bind rosr_regs rosr_regs_chk i_rosr_regs_chk (.i_clk, .i_rst, .i_ce, .i_host_mode_pin, .i_cmd_reg_reset_n, .i_wr_en,
  .i_rd_en, .i_addr, .i_wdata, .i_core_status, .o_rdata, .o_rvalid, .o_cfg, .o_tlc_invalid, .o_power_down, .o_locked);

// >>> rosr_host.sv
// Host controller model: register writes, reads and the clear command.
// Assumes strobes are sampled on the rising edge; lines move on the falling one.
module rosr_host (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_rvalid,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic [7:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_cmd_reg_reset_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_wr_en, o_rd_en, o_addr, o_wdata, o_cmd_reg_reset_n} = {2'h0, 8'h00, 16'h0000, 1'h1};
  // Released lines carry the inverse so that stale values never pass
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    {o_wr_en, o_addr, o_wdata} = {1'h1, a, d};
    @(negedge i_clk);
    {o_wr_en, o_addr, o_wdata} = {1'h0, ~a, ~d};
  endtask
  // A missing answer comes back unknown
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(negedge i_clk);
    {o_rd_en, o_addr} = {1'h1, a};
    @(negedge i_clk);
    {o_rd_en, o_addr} = {1'h0, ~a};
    q = (i_rvalid === 1'h1) ? i_rdata : 16'hxxxx;
  endtask
  // Command word with the register-reset bit low over two edges
  task automatic clr();
    @(negedge i_clk);
    o_cmd_reg_reset_n = 1'h0;
    repeat (2) @(negedge i_clk);
    o_cmd_reg_reset_n = 1'h1;
  endtask
endmodule // rosr_host

// >>> reclocker_override_status_regs_test.sv
// Self-checking bench for rosr_regs through the host model.
// Assumes rosr_pkg is compiled first and the checker is bound.
module reclocker_override_status_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Rows: override word, expected config, expected invalid flag
  localparam logic [28:0] ROWS [5] = '{{16'h0001, 12'h000, 1'h0}, {16'h0201, 12'h080, 1'h0},
    {16'h0101, 12'h080, 1'h1}, {16'h0000, 12'h4a5, 1'h0}, {16'h1fff, 12'hf7f, 1'h0}};
  logic                   i_clk, i_rst, i_ce, i_host_mode_pin;
  logic                   wr_en, rd_en, cmd_n, rvalid, tlc_inv, pd, locked;
  logic [7:0]             addr;
  logic [15:0]            wdata, rdata, q;
  rosr_pkg::rosr_cfg_t    pin_cfg, cfg;
  rosr_pkg::rosr_status_t core_st;
  int                     n_fail = 0, checks_done = 0, k;
  rosr_regs #(.LOCK_CYCLES(8)) i_rosr_regs (.i_clk, .i_rst, .i_ce, .i_host_mode_pin, .i_cmd_reg_reset_n(cmd_n),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_pin_cfg(pin_cfg), .i_core_status(core_st),
    .o_rdata(rdata), .o_rvalid(rvalid), .o_cfg(cfg), .o_tlc_invalid(tlc_inv), .o_power_down(pd), .o_locked(locked));
  rosr_host i_rosr_host (.i_clk, .i_rdata(rdata), .i_rvalid(rvalid), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata), .o_cmd_reg_reset_n(cmd_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  // Whole run is under a hundred cycles; this leaves ample margin
  initial begin
    #20000;
    n_fail++;
    give_verdict();
  end
  initial begin
    {i_rst, i_ce, i_host_mode_pin, pin_cfg, core_st} = {3'h7, 12'h4a5, 4'h0};
    repeat (6) @(negedge i_clk);
    i_rst = 1'h0;
    chk({pd, locked, rvalid, tlc_inv, cfg}, 16'h0000);
    foreach (ROWS[r]) begin
      i_rosr_host.wr(8'h0c, ROWS[r][28:13]);
      @(negedge i_clk);
      chk({3'h0, tlc_inv, cfg}, {3'h0, ROWS[r][0], ROWS[r][12:1]});
      i_rosr_host.rd(8'h0c, q);
      chk(q, ROWS[r][28:13]);
    end
    // Status is read-only; reserved bits and unmapped places read zero
    core_st = 4'hb;
    i_rosr_host.wr(8'h0d, 16'hffff);
    i_rosr_host.rd(8'h0d, q);
    chk(q, 16'h000b);
    i_rosr_host.rd(8'h05, q);
    chk(q, 16'h0000);
    core_st = 4'h4;
    repeat (3) @(negedge i_clk);
    chk({15'h0000, locked}, 16'h0000);
    for (k = 0; k < 12 && locked !== 1'h1; k++) @(negedge i_clk);
    i_rosr_host.rd(8'h0d, q);
    chk(q, 16'h0004);
    // Standby in host mode, then the host clear must undo it
    i_host_mode_pin = 1'h0;
    i_rosr_host.wr(8'h02, 16'h0008);
    repeat (2) @(negedge i_clk);
    chk({14'h0000, pd, locked}, 16'h0002);
    i_rosr_host.clr();
    i_rosr_host.rd(8'h0c, q);
    chk(q, 16'h0000);
    chk({15'h0000, pd}, 16'h0000);
    // Second reset in non-host mode restores the defaults
    i_host_mode_pin = 1'h1;
    i_rosr_host.wr(8'h0c, 16'h0201);
    i_rst = 1'h1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'h0;
    i_rosr_host.rd(8'h0c, q);
    chk(q, 16'h0000);
    // Clock enable low freezes the registers, so this write is never taken
    i_ce = 1'h0;
    i_rosr_host.wr(8'h0c, 16'h0201);
    i_ce = 1'h1;
    i_rosr_host.rd(8'h0c, q);
    chk(q, 16'h0000);
    chk({4'h0, cfg}, {4'h0, pin_cfg});
    give_verdict();
  end
endmodule // reclocker_override_status_regs_test
